// ---- rtl/smc_pkg.sv ----
// smc_pkg: constants and carriers for the sleep mode controller
// assumes an APB slave with 32-bit data; offsets 0x0/0x1 are register indices
package smc_pkg;
  localparam int unsigned SMC_IDX_SLEEP_CONTROL     = 0;
  localparam int unsigned SMC_IDX_REGULATOR_CONTROL = 1;
  localparam logic [11:0] SMC_ADDR_SLEEP_CONTROL     = 12'(4 * SMC_IDX_SLEEP_CONTROL);
  localparam logic [11:0] SMC_ADDR_REGULATOR_CONTROL = 12'(4 * SMC_IDX_REGULATOR_CONTROL);
  localparam logic [11:0] SMC_ADDR_STATUS            = 12'h008;
  localparam logic [7:0]  SMC_SLEEP_CONTROL_RESET     = 8'h00;
  localparam logic [7:0]  SMC_REGULATOR_CONTROL_RESET = 8'h00;
  localparam int unsigned SMC_ENABLE_BIT  = 0;
  localparam int unsigned SMC_MODE_LSB    = 1;
  localparam int unsigned SMC_POWER_LSB   = 0;
  localparam int unsigned SMC_LEAKAGE_BIT = 4;
  localparam logic [7:0]  SMC_CTRL_MASK   = 8'h0F;
  localparam logic [7:0]  SMC_VREG_MASK   = 8'h17;
  localparam logic [2:0]  SMC_MODE_IDLE    = 3'h0;
  localparam logic [2:0]  SMC_MODE_STANDBY = 3'h1;
  localparam logic [2:0]  SMC_MODE_PDOWN   = 3'h2;
  localparam logic [2:0]  SMC_POWER_AUTO   = 3'h0;
  localparam logic [2:0]  SMC_POWER_FULL   = 3'h1;
  localparam logic [1:0]  SMC_BROWNOUT_WAIT = 2'h3;
  localparam int unsigned SMC_WAKE_CYCLES  = 6;
  localparam logic [2:0]  SMC_WAKE_LOAD    = 3'(SMC_WAKE_CYCLES - 1);

  typedef enum logic [2:0] {
    SMC_ST_ACTIVE  = 3'b000,
    SMC_ST_SLEEP   = 3'b001,
    SMC_ST_STARTUP = 3'b010,
    SMC_ST_WAKE    = 3'b011
  } smc_state_e;

  // wake request lines, one per source class
  typedef struct packed {
    logic pin_async;   // pin change on a fully asynchronous pin
    logic pin_sync;    // pin change on a synchronous pin
    logic addr_match;  // two_wire_interface address match
    logic lut_out;     // configurable_logic output
    logic periodic;    // periodic_interrupt_timer
    logic brownout;    // brownout_detector level monitor
    logic rsb;         // run_in_standby peripherals (rtc, adc, ac, zcd, timers a/b)
    logic other;       // all remaining interrupts
  } smc_wake_s;

  // clock and power gates toward the clock controller
  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic rsb_clk_en;
    logic timer_d_clk_en;
    logic main_osc_en;
    logic rtc_osc_en;
    logic reg_low_power;
    logic htll_active;
  } smc_gate_s;
endpackage : smc_pkg

// ---- rtl/smc_wake_timer.sv ----
// smc_wake_timer: counts the six-cycle wake delay on the peripheral clock
// assumes start is a one-cycle pulse; done pulses when the count expires
`timescale 1ns/1ps
module smc_wake_timer (
  input  wire logic pclk,     // peripheral clock
  input  wire logic presetn,  // async reset, active low
  input  wire logic start,    // load the counter
  output logic      done      // one-cycle pulse at expiry
);
  import smc_pkg::*;
  logic [2:0] count;
  logic       busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 3'h0;
      busy  <= 1'b0;
    end else if (start) begin
      count <= SMC_WAKE_LOAD;
      busy  <= 1'b1;
    end else if (busy) begin
      if (count == 3'h0) begin
        busy <= 1'b0;
      end else begin
        count <= count - 3'h1;
      end
    end
  end

  assign done = busy && (count == 3'h0) && !start;
endmodule : smc_wake_timer

// ---- rtl/smc_sleep_controller.sv ----
// smc_sleep_controller: sleep mode controller with apb registers and clock gating
// assumes cpu sleep_instr pulses, wake lines are synchronous, osc/regulator/brown-out
// ready levels come from the clock controller and brown-out detector
//
// Contract
// [RULE1] software picks mode and sets sleep enable before sleeping
// [RULE2] sleep starts only on the sleep instruction, not on writes
// [RULE3] with no enabled wake source, only reset ends sleep; code also ends it on dbg_break
// [RULE4] auto power mode: low-power regulator asleep when only low-freq osc runs
// [RULE5] full power mode: regulator always at full performance
// [RULE6] idle stops cpu clock only; every interrupt wakes
// [RULE7] standby: peripheral runs and wakes only with its run-in-standby bit
// [RULE8] standby: listed peripherals need run-in-standby; others and type d timer stop
// [RULE9] power-down keeps watchdog and periodic timer running
// [RULE10] power-down wakes on pin change, address match, logic, periodic timer, brown-out
// [RULE11] logic wakes from power-down only with filter and edge detect zero
// [RULE12] standby and power-down: only asynchronous pins wake on pin change
// [RULE13] software disables address match and logic wake before hot low leakage
// [RULE14] power-down stops all oscillators except low-freq/rtc when needed
// [RULE15] wake takes six cycles, after osc and regulator start-up if off
// [RULE16] brown-out fuse 3 extends wake until detector is ready
// [RULE17] debugger break while asleep returns to active
// [RULE18] mode field: idle 0, standby 1, power-down 2, rest reserved
// [RULE19] power mode: auto 0, full 1, protected by change protection
// [RULE20] interrupt wake resumes after sleep; reset restarts from vector
// [RULE21] sleep instruction with sleep enable clear is ignored
`timescale 1ns/1ps
module smc_sleep_controller (
  input  wire logic             pclk,            // peripheral clock, 125 MHz
  input  wire logic             presetn,         // any system reset, active low
  input  wire logic             psel,            // apb select
  input  wire logic             penable,         // apb access phase
  input  wire logic             pwrite,          // apb write
  input  wire logic [11:0]      paddr,           // apb byte address
  input  wire logic [31:0]      pwdata,          // apb write data
  input  wire logic [3:0]       pstrb,           // apb byte strobes
  output logic      [31:0]      prdata,          // apb read data
  output logic                  pready,          // apb ready
  output logic                  pslverr,         // apb error
  input  wire logic             ccp_unlocked,    // change protection open
  input  wire logic             sleep_instr,     // cpu executes sleep, pulse
  input  wire logic             dbg_break,       // debugger break
  input  wire smc_pkg::smc_wake_s wake_req,      // raw wake requests
  input  wire smc_pkg::smc_wake_s wake_en,       // wake sources enabled
  input  wire logic             run_in_standby,  // any rsb peripheral has bit set
  input  wire logic             main_osc_rsb,    // main osc forced on in standby
  input  wire logic             rtc_osc_rsb,     // rtc osc forced on in standby
  input  wire logic             lfo_needed,      // low-freq osc feeds bod/wdt/pit
  input  wire logic             only_lfo_on,     // low-freq osc is only osc on
  input  wire logic [2:0]       lut_filter_select, // lookup_table filter field
  input  wire logic [1:0]       lut_edge_detect,   // lookup_table edge field
  input  wire logic [1:0]       brownout_fuse_config, // active/idle bod fuse field
  input  wire logic             brownout_ready,  // brownout detector ready
  input  wire logic             osc_ready,       // main oscillator started
  input  wire logic             reg_ready,       // regulator started
  output smc_pkg::smc_gate_s    gates,           // clock and power gates
  output logic                  asleep,          // cpu halted by sleep
  output logic                  wake_irq_pending // wake caused by interrupt
);
  import smc_pkg::*;

  logic [7:0]  sleep_control;
  logic [7:0]  regulator_control;
  smc_state_e  state;
  smc_state_e  next_state;
  logic [2:0]  mode;
  logic        osc_was_off;
  logic        wake_any;
  logic        wake_start;
  logic        wake_done;
  logic        brownout_wait_met;
  logic        apb_wr;
  logic        apb_rd;
  smc_gate_s   next_gates;

  function automatic logic mode_known(input logic [2:0] m);
    mode_known = (m == SMC_MODE_IDLE) || (m == SMC_MODE_STANDBY) || (m == SMC_MODE_PDOWN);
  endfunction : mode_known

  wire [2:0] sel_mode               = sleep_control[SMC_MODE_LSB +: 3];
  wire       sleep_enable_bit       = sleep_control[SMC_ENABLE_BIT];
  wire [2:0] regulator_power_mode   = regulator_control[SMC_POWER_LSB +: 3];
  wire       hot_low_leakage_enable = regulator_control[SMC_LEAKAGE_BIT];

  // apb: zero wait states, unmapped addresses raise pslverr
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != SMC_ADDR_SLEEP_CONTROL)
                   && (paddr != SMC_ADDR_REGULATOR_CONTROL) && (paddr != SMC_ADDR_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_control <= SMC_SLEEP_CONTROL_RESET;
    end else if (apb_wr && pstrb[0] && paddr == SMC_ADDR_SLEEP_CONTROL) begin
      sleep_control <= pwdata[7:0] & SMC_CTRL_MASK; // RULE2
    end
  end

  // regulator control only changes while change protection is open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regulator_control <= SMC_REGULATOR_CONTROL_RESET;
    end else if (apb_wr && pstrb[0] && ccp_unlocked
                 && paddr == SMC_ADDR_REGULATOR_CONTROL) begin
      regulator_control <= pwdata[7:0] & SMC_VREG_MASK; // RULE19
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        SMC_ADDR_SLEEP_CONTROL:     prdata <= {24'h00_0000, sleep_control};
        SMC_ADDR_REGULATOR_CONTROL: prdata <= {24'h00_0000, regulator_control};
        SMC_ADDR_STATUS:            prdata <= {28'h000_0000, 1'b0, state};
        default:                    prdata <= 32'h0000_0000;
      endcase
    end
  end

  // wake qualification per latched mode
  always_comb begin
    wake_any = 1'b0;
    case (mode)
      SMC_MODE_IDLE: begin
        wake_any = |(wake_req & wake_en); // RULE6
      end
      SMC_MODE_STANDBY: begin
        wake_any = (wake_req.pin_async & wake_en.pin_async)  // RULE12
                 | (wake_req.addr_match & wake_en.addr_match)
                 | (wake_req.periodic & wake_en.periodic)
                 | (wake_req.brownout & wake_en.brownout)
                 | (wake_req.lut_out & wake_en.lut_out & run_in_standby) // RULE8
                 | (wake_req.rsb & wake_en.rsb & run_in_standby); // RULE7
      end
      SMC_MODE_PDOWN: begin
        wake_any = (wake_req.pin_async & wake_en.pin_async)  // RULE10 RULE12
                 | (wake_req.addr_match & wake_en.addr_match & !hot_low_leakage_enable)
                 | (wake_req.lut_out & wake_en.lut_out & !hot_low_leakage_enable // RULE13
                    & (lut_filter_select == 3'h0) & (lut_edge_detect == 2'h0)) // RULE11
                 | (wake_req.periodic & wake_en.periodic)
                 | (wake_req.brownout & wake_en.brownout);
      end
      default: wake_any = 1'b0;
    endcase
  end

  assign brownout_wait_met = (brownout_fuse_config != SMC_BROWNOUT_WAIT) // RULE16
                          || brownout_ready;
  assign wake_start   = (state == SMC_ST_SLEEP && (wake_any || dbg_break) && !osc_was_off)
                     || (state == SMC_ST_STARTUP && osc_ready && reg_ready);

  smc_wake_timer u_wake_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wake_start),
    .done    (wake_done)
  );

  logic timer_expired;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_expired <= 1'b0;
    end else if (wake_start) begin
      timer_expired <= 1'b0;
    end else if (wake_done) begin
      timer_expired <= 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      SMC_ST_ACTIVE: begin
        if (sleep_instr && sleep_enable_bit && mode_known(sel_mode)) begin // RULE2 RULE21
          next_state = SMC_ST_SLEEP;
        end
      end
      SMC_ST_SLEEP: begin
        if (wake_any || dbg_break) begin // RULE3 RULE17
          next_state = osc_was_off ? SMC_ST_STARTUP : SMC_ST_WAKE;
        end
      end
      SMC_ST_STARTUP: begin
        if (osc_ready && reg_ready) begin // RULE15
          next_state = SMC_ST_WAKE;
        end
      end
      SMC_ST_WAKE: begin
        if ((wake_done || timer_expired) && brownout_wait_met) begin // RULE15 RULE16
          next_state = SMC_ST_ACTIVE;
        end
      end
      default: next_state = SMC_ST_ACTIVE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SMC_ST_ACTIVE; // RULE20
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode        <= SMC_MODE_IDLE;
      osc_was_off <= 1'b0;
    end else if (state == SMC_ST_ACTIVE && next_state == SMC_ST_SLEEP) begin
      mode        <= sel_mode; // RULE18
      osc_was_off <= (sel_mode == SMC_MODE_PDOWN)
                  || (sel_mode == SMC_MODE_STANDBY && !main_osc_rsb); // RULE15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_irq_pending <= 1'b0;
    end else if (state == SMC_ST_SLEEP && wake_any) begin
      wake_irq_pending <= 1'b1; // RULE20
    end else if (state == SMC_ST_ACTIVE) begin
      wake_irq_pending <= 1'b0;
    end
  end

  // gates follow state; asleep covers sleep, start-up and the wake count
  always_comb begin
    next_gates = '{default: 1'b1};
    next_gates.reg_low_power = 1'b0;
    next_gates.htll_active   = 1'b0;
    if (state == SMC_ST_SLEEP) begin
      next_gates.cpu_clk_en = 1'b0; // RULE6
      case (mode)
        SMC_MODE_STANDBY: begin
          next_gates.per_clk_en  = 1'b0;
          next_gates.rsb_clk_en  = run_in_standby; // RULE7 RULE8
          next_gates.timer_d_clk_en = 1'b0; // RULE8
          next_gates.main_osc_en = main_osc_rsb;
          next_gates.rtc_osc_en  = rtc_osc_rsb;
        end
        SMC_MODE_PDOWN: begin
          next_gates.per_clk_en  = 1'b0; // RULE9
          next_gates.rsb_clk_en  = 1'b0;
          next_gates.timer_d_clk_en = 1'b0;
          next_gates.main_osc_en = 1'b0; // RULE14
          next_gates.rtc_osc_en  = lfo_needed; // RULE14
          next_gates.htll_active = hot_low_leakage_enable
                                && (regulator_power_mode == SMC_POWER_AUTO);
        end
        default: begin
        end
      endcase
      next_gates.reg_low_power = (regulator_power_mode == SMC_POWER_AUTO) // RULE4 RULE5
                              && only_lfo_on;
    end else if (state == SMC_ST_STARTUP || state == SMC_ST_WAKE) begin
      next_gates.cpu_clk_en = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates <= '{default: 1'b1, reg_low_power: 1'b0, htll_active: 1'b0};
    end else begin
      gates <= next_gates;
    end
  end

  assign asleep = (state != SMC_ST_ACTIVE);

  a_ignore_no_enable: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    (state == SMC_ST_ACTIVE && sleep_instr && !sleep_enable_bit) |=> state == SMC_ST_ACTIVE)
    else $error("sleep taken with enable clear");
  a_sleep_needs_instr: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (state == SMC_ST_ACTIVE && !sleep_instr) |=> state == SMC_ST_ACTIVE)
    else $error("sleep entered without instruction");
  a_stay_asleep: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    (state == SMC_ST_SLEEP && !wake_any && !dbg_break) |=> state == SMC_ST_SLEEP)
    else $error("woke without source");
  a_dbg_wakes: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    (state == SMC_ST_SLEEP && dbg_break && !osc_was_off) |=> state == SMC_ST_WAKE)
    else $error("debug break did not wake");
  sequence s_wake_begin;
    state == SMC_ST_SLEEP && (wake_any || dbg_break) && !osc_was_off;
  endsequence
  a_wake_six: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    s_wake_begin |=> (state == SMC_ST_WAKE)[*6])
    else $error("wake shorter than six cycles");
  a_wake_bound: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    (s_wake_begin ##1 brownout_wait_met[*7]) |-> state == SMC_ST_ACTIVE)
    else $error("wake longer than six cycles");
  a_brownout_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    (state == SMC_ST_WAKE && !brownout_wait_met) |=> state != SMC_ST_ACTIVE)
    else $error("wake ended before brown-out ready");
  a_full_reg: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    (regulator_power_mode == SMC_POWER_FULL) |=> !gates.reg_low_power)
    else $error("low-power regulator in full mode");
  a_pdown_osc: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    (state == SMC_ST_SLEEP && mode == SMC_MODE_PDOWN) |=> !gates.main_osc_en)
    else $error("main osc on in power-down");
  a_idle_per: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    (state == SMC_ST_SLEEP && mode == SMC_MODE_IDLE) |=> gates.per_clk_en && !gates.cpu_clk_en)
    else $error("idle gating wrong");
  a_pd_lut_path: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    (state == SMC_ST_SLEEP && mode == SMC_MODE_PDOWN && lut_edge_detect != 2'h0
     && !wake_req.pin_async && !wake_req.addr_match && !wake_req.periodic && !wake_req.brownout
     && !dbg_break) |=> state == SMC_ST_SLEEP)
    else $error("synchronous logic path woke power-down");
endmodule : smc_sleep_controller

// ---- tb/smc_cpu_model.sv ----
// smc_cpu_model: cpu core side, turns a bench request into a sleep instruction pulse
// assumes the bench has written sleep_control before raising go_req
`timescale 1ns/1ps
module smc_cpu_model (
  input  wire logic pclk,        // peripheral clock
  input  wire logic presetn,     // async reset, active low
  input  wire logic go_req,      // bench asks the core to sleep
  output logic      sleep_instr  // one-cycle sleep instruction
);
  // the bench configures mode and enable first; core only executes the instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_instr <= 1'b0;
    end else begin
      sleep_instr <= go_req;
    end
  end
  // bench never asks for address-match or logic wake while hot low leakage is set
endmodule : smc_cpu_model

// ---- tb/tb_sleep_mode_controller.sv ----
// tb_sleep_mode_controller: self-checking bench for the sleep controller
// assumes a zero-wait apb slave and registered gate outputs
`timescale 1ns/1ps
module tb_sleep_mode_controller;
  import smc_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, asleep, wake_irq_pending, sleep_instr, go_req = 1'b0;
  logic        ccp_unlocked = 1'b0, dbg_break = 1'b0, run_in_standby = 1'b0;
  logic        main_osc_rsb = 1'b0, rtc_osc_rsb = 1'b0, lfo_needed = 1'b0, only_lfo_on = 1'b0;
  logic [2:0]  lut_filter_select = 3'h0;
  logic [1:0]  lut_edge_detect = 2'h0, brownout_fuse_config = 2'h0;
  logic        brownout_ready = 1'b1, osc_ready = 1'b1, reg_ready = 1'b1;
  smc_wake_s   wake_req = '0, wake_en = '1;
  smc_gate_s   gates;
  int          bad_count = 0, checked = 0;
  logic [31:0] rd;
  logic        er;

  always #4 pclk = ~pclk;

  smc_sleep_controller dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ccp_unlocked(ccp_unlocked),
    .sleep_instr(sleep_instr), .dbg_break(dbg_break), .wake_req(wake_req),
    .wake_en(wake_en), .run_in_standby(run_in_standby), .main_osc_rsb(main_osc_rsb),
    .rtc_osc_rsb(rtc_osc_rsb), .lfo_needed(lfo_needed), .only_lfo_on(only_lfo_on),
    .lut_filter_select(lut_filter_select), .lut_edge_detect(lut_edge_detect),
    .brownout_fuse_config(brownout_fuse_config), .brownout_ready(brownout_ready),
    .osc_ready(osc_ready), .reg_ready(reg_ready), .gates(gates), .asleep(asleep),
    .wake_irq_pending(wake_irq_pending));

  smc_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .go_req(go_req),
    .sleep_instr(sleep_instr));

  task automatic report_and_stop;
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // observation point one ns past the edge, after its updates land
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic go_sleep(input logic [7:0] c);
    apb(1'b1, SMC_ADDR_SLEEP_CONTROL, {24'h0, c});
    go_req <= 1'b1;
    @(posedge pclk);
    go_req <= 1'b0;
    tick(3);
  endtask : go_sleep

  task automatic wait_wake(input int lo, input int hi);
    int n;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (asleep === 1'b1 && n < 60);
    chk("wake_cycles_in_range", 32'h1, {31'h0, n >= lo && n <= hi});
    // return on an edge so callers drive inputs there
    @(posedge pclk);
  endtask : wait_wake

  task automatic t_reset;
    apb(1'b0, SMC_ADDR_SLEEP_CONTROL, 32'h0);
    chk("sleep_control", {24'h0, SMC_SLEEP_CONTROL_RESET}, rd);
    apb(1'b0, SMC_ADDR_REGULATOR_CONTROL, 32'h0);
    chk("regulator_control", {24'h0, SMC_REGULATOR_CONTROL_RESET}, rd);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    chk("gates_reset", 32'hFC, {24'h0, gates});
  endtask : t_reset

  task automatic t_no_sleep;
    apb(1'b1, SMC_ADDR_SLEEP_CONTROL, 32'h3);
    tick(5);
    chk("asleep_after_write", 32'h0, {31'h0, asleep});
    go_sleep(8'h02);
    chk("asleep_sen_clear", 32'h0, {31'h0, asleep});
    go_sleep(8'h07);
    chk("asleep_reserved_mode", 32'h0, {31'h0, asleep});
  endtask : t_no_sleep

  task automatic t_idle;
    go_sleep(8'h01);
    chk("asleep_idle", 32'h1, {31'h0, asleep});
    chk("idle_clocks", 32'h3,
        {30'h0, gates.cpu_clk_en, gates.per_clk_en, gates.main_osc_en});
    @(posedge pclk);
    wake_req.other <= 1'b1;
    tick(2);
    chk("wake_irq_pending", 32'h1, {31'h0, wake_irq_pending});
    wait_wake(4, 6);
    wake_req <= '0;
  endtask : t_idle

  task automatic t_standby;
    main_osc_rsb <= 1'b1;
    go_sleep(8'h03);
    chk("stby_cpu_timer_rsb", 32'h0,
        {29'h0, gates.cpu_clk_en, gates.timer_d_clk_en, gates.rsb_clk_en});
    @(posedge pclk);
    wake_req.other <= 1'b1; wake_req.rsb <= 1'b1; wake_req.pin_sync <= 1'b1;
    tick(20);
    chk("stby_stays_asleep", 32'h1, {31'h0, asleep});
    @(posedge pclk);
    run_in_standby <= 1'b1;
    wait_wake(1, 12);
    wake_req <= '0; run_in_standby <= 1'b0; main_osc_rsb <= 1'b0;
  endtask : t_standby

  task automatic t_pdown;
    lut_filter_select <= 3'h1; lfo_needed <= 1'b1;
    go_sleep(8'h05);
    chk("pdown_osc", 32'h1, {30'h0, gates.main_osc_en, gates.rtc_osc_en});
    chk("pdown_per_clk", 32'h0, {31'h0, gates.per_clk_en});
    @(posedge pclk);
    wake_req.lut_out <= 1'b1; wake_req.pin_sync <= 1'b1;
    wake_req.other <= 1'b1; osc_ready <= 1'b0;
    tick(20);
    chk("pdown_stays_asleep", 32'h1, {31'h0, asleep});
    @(posedge pclk);
    lut_filter_select <= 3'h0; lut_edge_detect <= 2'h1;
    tick(20);
    chk("pdown_edge_asleep", 32'h1, {31'h0, asleep});
    @(posedge pclk);
    lut_edge_detect <= 2'h0;
    tick(20);
    chk("pdown_waits_osc", 32'h1, {31'h0, asleep});
    @(posedge pclk);
    osc_ready <= 1'b1;
    wait_wake(6, 9);
    wake_req <= '0; lfo_needed <= 1'b0;
  endtask : t_pdown

  task automatic t_noen_dbg_reset;
    wake_en <= '0;
    go_sleep(8'h01);
    @(posedge pclk);
    wake_req <= '1;
    tick(30);
    chk("no_source_asleep", 32'h1, {31'h0, asleep});
    apb(1'b0, SMC_ADDR_STATUS, 32'h0);
    chk("status_sleep", {29'h0, SMC_ST_SLEEP}, rd);
    @(posedge pclk);
    dbg_break <= 1'b1;
    tick(2);
    chk("dbg_not_irq", 32'h0, {31'h0, wake_irq_pending});
    wait_wake(1, 10);
    dbg_break <= 1'b0;
    go_sleep(8'h01);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    chk("reset_ends_sleep", 32'h0, {31'h0, asleep});
    chk("reset_gates", 32'hFC, {24'h0, gates});
    @(posedge pclk);
    presetn <= 1'b1; wake_req <= '0; wake_en <= '1;
  endtask : t_noen_dbg_reset

  task automatic t_regulator;
    apb(1'b1, SMC_ADDR_REGULATOR_CONTROL, 32'h1);
    apb(1'b0, SMC_ADDR_REGULATOR_CONTROL, 32'h0);
    chk("vreg_locked", 32'h0, rd);
    ccp_unlocked <= 1'b1;
    apb(1'b1, SMC_ADDR_REGULATOR_CONTROL, 32'h1);
    apb(1'b0, SMC_ADDR_REGULATOR_CONTROL, 32'h0);
    chk("vreg_full", 32'h1, rd);
    only_lfo_on <= 1'b1;
    for (int m = 1; m >= 0; m--) begin
      apb(1'b1, SMC_ADDR_REGULATOR_CONTROL, 32'(m));
      go_sleep(8'h01);
      chk("reg_low_power", 32'(1 - m), {31'h0, gates.reg_low_power});
      @(posedge pclk);
      wake_req.other <= 1'b1;
      wait_wake(6, 8);
      wake_req <= '0;
    end
    apb(1'b1, SMC_ADDR_REGULATOR_CONTROL, 32'h10);
    go_sleep(8'h05);
    chk("htll_active", 32'h1, {31'h0, gates.htll_active});
    @(posedge pclk);
    wake_req.periodic <= 1'b1;
    wait_wake(6, 9);
    wake_req <= '0;
    apb(1'b1, SMC_ADDR_REGULATOR_CONTROL, 32'h0);
    only_lfo_on <= 1'b0; ccp_unlocked <= 1'b0;
  endtask : t_regulator

  task automatic t_bod;
    brownout_fuse_config <= 2'h3; brownout_ready <= 1'b0;
    go_sleep(8'h01);
    @(posedge pclk);
    wake_req.other <= 1'b1;
    tick(20);
    chk("brownout_extends_wake", 32'h1, {31'h0, asleep});
    @(posedge pclk);
    brownout_ready <= 1'b1;
    wait_wake(1, 4);
    wake_req <= '0; brownout_fuse_config <= 2'h0;
  endtask : t_bod

  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_no_sleep();
    t_idle();
    t_standby();
    t_pdown();
    t_noen_dbg_reset();
    t_regulator();
    t_bod();
    report_and_stop();
  end
endmodule : tb_sleep_mode_controller
